//--- core/accm_pkg.sv
// package: addresses, field layout, reset values and timing of the accessory interrupt registers
package accm_pkg;

  // register addresses inside the immediate range (6-bit ulpi address)
  localparam logic [5:0] ADDR_IEN_WR = 6'h1D;
  localparam logic [5:0] ADDR_IEN_SET = 6'h1E;
  localparam logic [5:0] ADDR_IEN_CLR = 6'h1F;
  localparam logic [5:0] ADDR_STAT = 6'h20;
  localparam logic [5:0] ADDR_LATCH = 6'h21;
  localparam logic [5:0] ADDR_RID_WR = 6'h36;
  localparam logic [5:0] ADDR_RID_SET = 6'h37;
  localparam logic [5:0] ADDR_RID_CLR = 6'h38;
  localparam logic [5:0] ADDR_VEND_LO = 6'h30;
  localparam logic [5:0] ADDR_VEND_HI = 6'h3F;
  // immediate address that announces an extended address byte
  localparam logic [5:0] ADDR_EXT = 6'h2F;

  // ulpi transmit command byte
  localparam int CMD_TYPE_HI = 7;
  localparam int CMD_TYPE_LO = 6;
  localparam logic [1:0] CMD_REGW = 2'h2;
  localparam logic [1:0] CMD_REGR = 2'h3;
  localparam logic [1:0] EXT_RANGE_IMM = 2'h0;

  // register operation codes, offset from the base address of a trio
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_CLEAR = 2'h2;

  // accessory_irq_enable fields
  localparam int IEN_OPEN_RISE = 0;
  localparam int IEN_OPEN_FALL = 1;
  localparam int IEN_RES = 5;
  localparam logic [7:0] IEN_MASK = 8'h23;
  localparam logic [7:0] IEN_RST = 8'h00;

  // accessory_irq_status fields
  localparam int STAT_OPEN = 0;
  localparam int STAT_CODE_LO = 3;
  localparam int STAT_DONE = 6;

  // accessory_irq_latch fields
  localparam int LATCH_OPEN = 0;
  localparam int LATCH_RES = 3;

  // vendor resistor measurement register fields
  localparam int RID_CODE_LO = 0;
  localparam int RID_DONE = 3;
  localparam int RID_GO = 4;
  localparam int RID_SPARE = 5;
  localparam int RID_IEN = 6;
  localparam logic [2:0] RID_CODE_RST = 3'h0;

  // receive command byte
  localparam int RXCMD_ALT = 7;

  // measurement time
  localparam int CLK_PERIOD_NS = 20;
  localparam int MEAS_TIME_NS = 282000;
  localparam int MEAS_CYCLES = (MEAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MEAS_CNT_W = 15;

  // register access engine, gray along the idle-command-extended-data path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CACK = 3'h1,
    ST_EXT = 3'h3,
    ST_WDATA = 3'h2,
    ST_WSTP = 3'h6,
    ST_TURN = 3'h7,
    ST_DRIVE = 3'h5
  } accm_state_e;

endpackage

//--- core/accm_sync.sv
// module: two-flop synchroniser for asynchronous analogue status levels
`timescale 1ns/100ps
module accm_sync
  import accm_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

//--- core/accm_res_meter.sv
// module: timer that frames one id resistor measurement
`timescale 1ns/100ps
module accm_res_meter
  import accm_pkg::*;
#(
  parameter int MEAS_LEN = MEAS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [MEAS_CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  wire last_w = (cnt_r == MEAS_CNT_W'(MEAS_LEN - 1));

  // a start while busy is ignored; the running measurement is not restarted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      done_r <= busy_r & last_w;
      if (!busy_r) begin
        cnt_r <= '0;
        busy_r <= start;
      end else if (last_w) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;

endmodule

//--- core/accm_irq_regs.sv
// module: accessory interrupt registers with ulpi register access and alt_int reporting
//
// Notes on behaviour
// - enable register reads at 1Dh-1Fh; 1Dh writes, 1Eh sets, 1Fh clears.
// - open-rise enable raises alt_int when the id pin goes floating.
// - open-fall enable raises alt_int when the id pin stops floating.
// - unimplemented detect and d-plus bits always read zero.
// - enable bit 5 raises alt_int when measurement done asserts.
// - effective measurement interrupt enable is enable bit 5 or vendor enable.
// - status register is read-only; bit 0 shows present id floating state.
// - status bits 5:3 carry the measured id resistor code.
// - status bit 6 sets when the 282 us measurement completes.
// - done clears only on a read of the vendor measurement register.
// - latch register is read-only and its event bits clear on read.
// - latch bit 0 records enabled floating rise or fall events.
// - latch bit 3 records done rising while measurement interrupt enabled.
// - immediate registers reachable by immediate or extended address.
// - vendor range 30h-3Fh served by ordinary immediate accesses.
// - setting vendor bit 4 starts a measurement; it self-clears on completion.
`timescale 1ns/100ps
module accm_irq_regs
  import accm_pkg::*;
#(
  parameter int MEAS_LEN = MEAS_CYCLES
) (
  // clock, reset and enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // ulpi link pins, data is a two-way bus split in three
  input wire logic [7:0] ulpi_data_in,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic ulpi_stp,
  // remaining receive command bits from the phy core, same clock
  input wire logic [6:0] rxcmd_low,
  // analogue id circuitry, asynchronous
  input wire logic ident_open_raw,
  input wire logic [2:0] resistor_code_raw,
  // measurement window for the analogue converter
  output logic resistor_measure_active
);

  // register access engine state
  accm_state_e state_r;
  accm_state_e state_nxt;
  logic [7:0] cmd_r;
  logic [7:0] addr_r;
  logic [7:0] wdata_r;
  logic rx_r;
  logic nxt_r;
  logic nxt_nxt;
  logic dir_r;
  logic dir_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;

  // register contents
  logic [7:0] ien_r;
  logic lat_open_r;
  logic lat_res_r;
  logic [2:0] code_r;
  logic done_r;
  logic go_r;
  logic spare_r;
  logic rid_ien_r;
  logic alt_pend_r;
  logic open_prev_r;

  // synchronised analogue levels and measurement timer handshake
  logic [3:0] ana_s;
  logic meter_busy;
  logic meter_done;

  // decode helpers
  function automatic logic in_trio(input logic [5:0] a, input logic [5:0] base);
    logic hit;
    hit = (a >= base) && (a <= base + 6'h02);
    return hit;
  endfunction

  function automatic logic [7:0] reg_update(input logic [7:0] cur, input logic [1:0] op, input logic [7:0] wd);
    logic [7:0] res;
    res = cur;
    unique case (op)
      OP_WRITE: res = wd;
      OP_SET: res = cur | wd;
      OP_CLEAR: res = cur & ~wd;
      default: res = cur;
    endcase
    return res;
  endfunction

  // the id comparator and converter output are not on this clock
  accm_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({resistor_code_raw, ident_open_raw}),
    .sync_out(ana_s)
  );

  wire open_s = ana_s[0];
  wire [2:0] code_s = ana_s[3:1];

  // command decode on the link byte while the bus is ours to listen to
  wire [1:0] in_type = ulpi_data_in[CMD_TYPE_HI:CMD_TYPE_LO];
  wire is_cmd = ~dir_r & ((in_type == CMD_REGW) | (in_type == CMD_REGR));
  wire wr_cmd = (cmd_r[CMD_TYPE_HI:CMD_TYPE_LO] == CMD_REGW);
  wire ext_cmd = (cmd_r[5:0] == ADDR_EXT);

  // extended addresses above the immediate range reach nothing here
  wire in_range = (addr_r[7:6] == EXT_RANGE_IMM);
  wire [5:0] a6 = addr_r[5:0];
  wire in_vendor = in_range & (a6 >= ADDR_VEND_LO) & (a6 <= ADDR_VEND_HI);
  wire ien_hit = in_range & in_trio(a6, ADDR_IEN_WR);
  wire rid_hit = in_vendor & in_trio(a6, ADDR_RID_WR);
  wire stat_hit = in_range & (a6 == ADDR_STAT);
  wire latch_hit = in_range & (a6 == ADDR_LATCH);
  wire [5:0] ien_off = a6 - ADDR_IEN_WR;
  wire [5:0] rid_off = a6 - ADDR_RID_WR;

  // read images, unimplemented and reserved bits are constant zero
  wire [7:0] ien_byte = ien_r & IEN_MASK;
  wire [7:0] stat_byte = {1'b0, done_r, code_r, 2'b00, open_s};
  wire [7:0] latch_byte = {4'h0, lat_res_r, 2'b00, lat_open_r};
  wire [7:0] rid_byte = {1'b0, rid_ien_r, spare_r, go_r, done_r, code_r};

  // read selection; the status address has no write path at all
  wire [7:0] rd_byte = ien_hit ? ien_byte :
                       stat_hit ? stat_byte :
                       latch_hit ? latch_byte :
                       rid_hit ? rid_byte : 8'h00;

  // the read side effects happen on the edge the byte is committed
  wire rd_commit = (state_r == ST_TURN) & ~rx_r;
  wire rd_latch = rd_commit & latch_hit;
  wire rd_rid = rd_commit & rid_hit;
  wire rx_sent = (state_r == ST_TURN) & rx_r;

  // writes take effect when the link ends the frame with stop
  wire wr_fire = (state_r == ST_WSTP) & ulpi_stp;
  wire ien_wr = wr_fire & ien_hit;
  wire rid_wr = wr_fire & rid_hit;
  wire [7:0] ien_upd = reg_update(ien_r, ien_off[1:0], wdata_r) & IEN_MASK;
  wire [7:0] rid_upd = reg_update(rid_byte, rid_off[1:0], wdata_r);

  // measurement start on a write or set that raises the go bit
  wire meas_start = rid_wr & rid_upd[RID_GO] & ~go_r;

  accm_res_meter #(
    .MEAS_LEN(MEAS_LEN)
  ) u_meter (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(meas_start),
    .busy(meter_busy),
    .done(meter_done)
  );

  // id floating edges, enabled per direction
  wire open_rise = open_s & ~open_prev_r;
  wire open_fall = ~open_s & open_prev_r;
  wire ev_open = (open_rise & ien_r[IEN_OPEN_RISE]) | (open_fall & ien_r[IEN_OPEN_FALL]);
  // the two enables are ored so either register can arm the event
  wire res_ien_eff = ien_r[IEN_RES] | rid_ien_r;
  wire ev_res = meter_done & ~done_r & res_ien_eff;
  wire ev_any = ev_open | ev_res;

  // next values; an event in the clearing cycle wins over the clear
  wire lat_open_nxt = ev_open | (lat_open_r & ~rd_latch);
  wire lat_res_nxt = ev_res | (lat_res_r & ~rd_latch);
  wire done_nxt = meter_done | (done_r & ~rd_rid);
  wire alt_pend_nxt = ev_any | (alt_pend_r & ~rx_sent);
  wire go_nxt = meter_done ? 1'b0 : (rid_wr ? rid_upd[RID_GO] : go_r);
  wire [2:0] code_nxt = meter_done ? code_s : (rid_wr ? rid_upd[RID_CODE_LO +: 3] : code_r);
  wire [7:0] rxcmd_byte = {alt_pend_r, rxcmd_low};

  // access sequencing; a link command goes before a pending receive command
  always_comb begin
    state_nxt = state_r;
    nxt_nxt = 1'b0;
    dir_nxt = dir_r;
    oe_nxt = oe_r;
    dout_nxt = dout_r;
    unique case (state_r)
      ST_IDLE: begin
        if (is_cmd) begin
          nxt_nxt = 1'b1;
          state_nxt = ST_CACK;
        end else if (alt_pend_r) begin
          dir_nxt = 1'b1;
          state_nxt = ST_TURN;
        end
      end
      ST_CACK: begin
        if (ext_cmd) begin
          nxt_nxt = 1'b1;
          state_nxt = ST_EXT;
        end else if (wr_cmd) begin
          nxt_nxt = 1'b1;
          state_nxt = ST_WDATA;
        end else begin
          dir_nxt = 1'b1;
          state_nxt = ST_TURN;
        end
      end
      ST_EXT: begin
        if (wr_cmd) begin
          nxt_nxt = 1'b1;
          state_nxt = ST_WDATA;
        end else begin
          dir_nxt = 1'b1;
          state_nxt = ST_TURN;
        end
      end
      ST_WDATA: begin
        state_nxt = ST_WSTP;
      end
      ST_WSTP: begin
        if (ulpi_stp) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TURN: begin
        oe_nxt = 1'b1;
        dout_nxt = rx_r ? rxcmd_byte : rd_byte;
        state_nxt = ST_DRIVE;
      end
      ST_DRIVE: begin
        dir_nxt = 1'b0;
        oe_nxt = 1'b0;
        dout_nxt = 8'h00;
        state_nxt = ST_IDLE;
      end
      default: begin
        dir_nxt = 1'b0;
        oe_nxt = 1'b0;
        dout_nxt = 8'h00;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // link-facing engine registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      nxt_r <= 1'b0;
      dir_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      nxt_r <= nxt_nxt;
      dir_r <= dir_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
    end
  end

  // command, address and data capture while nxt accepts each byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rx_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == ST_IDLE) begin
        rx_r <= ~is_cmd;
      end
      if ((state_r == ST_IDLE) && is_cmd) begin
        cmd_r <= ulpi_data_in;
        addr_r <= {2'b00, ulpi_data_in[5:0]};
      end
      if (state_r == ST_EXT) begin
        addr_r <= ulpi_data_in;
      end
      if (state_r == ST_WDATA) begin
        wdata_r <= ulpi_data_in;
      end
    end
  end

  // enable register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ien_r <= IEN_RST;
    end else if (clk_en && ien_wr) begin
      ien_r <= ien_upd;
    end
  end

  // vendor measurement fields; done is owned by the meter and the read path
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      code_r <= RID_CODE_RST;
      done_r <= 1'b0;
      go_r <= 1'b0;
      spare_r <= 1'b0;
      rid_ien_r <= 1'b0;
    end else if (clk_en) begin
      code_r <= code_nxt;
      done_r <= done_nxt;
      go_r <= go_nxt;
      if (rid_wr) begin
        spare_r <= rid_upd[RID_SPARE];
        rid_ien_r <= rid_upd[RID_IEN];
      end
    end
  end

  // event latches and pending alternate interrupt
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lat_open_r <= 1'b0;
      lat_res_r <= 1'b0;
      alt_pend_r <= 1'b0;
      open_prev_r <= 1'b0;
    end else if (clk_en) begin
      lat_open_r <= lat_open_nxt;
      lat_res_r <= lat_res_nxt;
      alt_pend_r <= alt_pend_nxt;
      open_prev_r <= open_s;
    end
  end

  // outputs, all registered
  assign ulpi_data_out = dout_r;
  assign ulpi_data_oe = oe_r;
  assign ulpi_dir = dir_r;
  assign ulpi_nxt = nxt_r;
  assign resistor_measure_active = meter_busy;

endmodule

//--- bench/accm_irq_regs_props.sv
// checker: port timing of the accessory interrupt register block
`timescale 1ns/100ps
module accm_irq_regs_props
  import accm_pkg::*;
#(
  parameter int MEAS_LEN = MEAS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // ulpi pins
  input wire logic [7:0] ulpi_data_in,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic ulpi_stp,
  // phy core and analogue side
  input wire logic [6:0] rxcmd_low,
  input wire logic ident_open_raw,
  input wire logic [2:0] resistor_code_raw,
  input wire logic resistor_measure_active
);
  int meas_cnt_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !clk_en);
  // enabled cycles spent in the current measurement window
  always_ff @(posedge clock) begin
    if (!rst_n) meas_cnt_r <= 0;
    else if (clk_en) meas_cnt_r <= resistor_measure_active ? meas_cnt_r + 1 : 0;
  end
  // turnaround, one driven byte, then release
  sequence s_phy_frame;
    ulpi_dir ##1 (ulpi_dir && ulpi_data_oe) ##1 (!ulpi_dir && !ulpi_data_oe);
  endsequence
  a_phy_frame_shape: assert property ($rose(ulpi_dir) |-> s_phy_frame)
    else $error("phy frame shape wrong");
  a_rxcmd_alt_byte: assert property (ulpi_data_oe && !$past(ulpi_nxt, 2) |-> ulpi_data_out == {1'b1, $past(rxcmd_low)})
    else $error("receive command byte wrong");
  a_nxt_after_cmd: assert property ($rose(ulpi_nxt) |-> $past(ulpi_data_in[7]) && !$past(ulpi_dir))
    else $error("nxt without a command byte");
  a_nxt_burst_len: assert property (ulpi_nxt [*3] |=> !ulpi_nxt)
    else $error("nxt held too long");
  a_nxt_dir_apart: assert property (!(ulpi_nxt && ulpi_dir))
    else $error("nxt during dir");
  a_idle_bus_zero: assert property (!ulpi_data_oe |-> ulpi_data_out == 8'h00)
    else $error("data driven while not enabled");
  a_meas_window_len: assert property ($fell(resistor_measure_active) |-> meas_cnt_r == MEAS_LEN)
    else $error("measurement window length wrong");
  a_meas_start_cause: assert property ($rose(resistor_measure_active) |-> $past(ulpi_stp))
    else $error("measurement started without a write");
endmodule
bind accm_irq_regs accm_irq_regs_props #(.MEAS_LEN(MEAS_LEN)) accm_irq_regs_props_i (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .ulpi_data_in(ulpi_data_in),
  .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .ulpi_dir(ulpi_dir),
  .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp), .rxcmd_low(rxcmd_low), .ident_open_raw(ident_open_raw),
  .resistor_code_raw(resistor_code_raw), .resistor_measure_active(resistor_measure_active));

//--- bench/accm_link_model.sv
// link model: ulpi register cycles and receive command capture
`timescale 1ns/100ps
module accm_link_model
  import accm_pkg::*;
(
  // clock
  input wire logic clock,
  // phy side
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe,
  // link side
  output logic [7:0] ulpi_data_in,
  output logic ulpi_stp = 1'b0
);
  logic [7:0] d_r = 8'h00;
  logic [7:0] junk_r = 8'h5A;
  logic reading = 1'b0;
  int rx_cnt = 0;
  // handshakes that never saw nxt; the bench fails the run on any
  int lost = 0;
  logic [7:0] rx_last = 8'h00;
  // nobody drives during turnaround: show a changing pattern, never a stale byte
  assign ulpi_data_in = ulpi_data_oe ? ulpi_data_out : (ulpi_dir ? junk_r : d_r);
  always @(posedge clock) junk_r <= ~ulpi_data_in;
  // phy drive outside a register read is a receive command
  always @(negedge clock) begin
    if (ulpi_data_oe && !reading) begin
      rx_cnt++;
      rx_last = ulpi_data_out;
    end
  end
  // present one byte and hold it until nxt; the id pull-up is taken as on
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clock);
    if (ulpi_dir === 1'b1) begin
      while (ulpi_dir === 1'b1) @(negedge clock);
      @(negedge clock);
    end
    d_r = b;
    while (ulpi_nxt !== 1'b1 && n < 16) begin
      @(negedge clock);
      n++;
    end
    if (ulpi_nxt !== 1'b1) lost++;
  endtask
  // write, set or clear, immediate or extended address
  task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic ext);
    put({CMD_REGW, ext ? ADDR_EXT : a});
    if (ext) put({2'b00, a});
    put(v);
    @(negedge clock);
    d_r = 8'h00;
    ulpi_stp = 1'b1;
    @(negedge clock);
    ulpi_stp = 1'b0;
  endtask
  // register read; data taken in the cycle the phy drives it
  task automatic rd(input logic [5:0] a, input logic ext, output logic [7:0] v);
    int n;
    n = 0;
    reading = 1'b1;
    put({CMD_REGR, ext ? ADDR_EXT : a});
    if (ext) put({2'b00, a});
    @(negedge clock);
    d_r = 8'h00;
    while (ulpi_data_oe !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    // a read that never answers shows the inverse, so no expected value can match it
    v = (ulpi_data_oe === 1'b1) ? ulpi_data_out : ~ulpi_data_out;
    @(negedge clock);
    reading = 1'b0;
    @(negedge clock);
  endtask
endmodule

//--- bench/accm_irq_regs_tb.sv
// testbench: register access, id events and resistor measurement
`timescale 1ns/100ps
module accm_irq_regs_tb;
  import accm_pkg::*;
  localparam int LEN = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [6:0] rxcmd_low = 7'h2B;
  logic ident_open_raw = 1'b0;
  logic [2:0] resistor_code_raw = 3'h0;
  logic [7:0] ulpi_data_in;
  logic [7:0] ulpi_data_out;
  logic ulpi_data_oe, ulpi_dir, ulpi_nxt, ulpi_stp, resistor_measure_active, ev;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int rx0, n;
  logic [7:0] v;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  // design and link
  accm_irq_regs #(.MEAS_LEN(LEN)) accm_irq_regs_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_stp(ulpi_stp), .rxcmd_low(rxcmd_low),
    .ident_open_raw(ident_open_raw), .resistor_code_raw(resistor_code_raw),
    .resistor_measure_active(resistor_measure_active));
  accm_link_model accm_link_model_i (.clock(clock), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .ulpi_data_in(ulpi_data_in),
    .ulpi_stp(ulpi_stp));
  initial forever #10 clock = ~clock;
  // hang guard well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic ext, input logic [7:0] e, input string what);
    accm_link_model_i.rd(a, ext, v);
    check(what, v, e);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    rchk(ADDR_IEN_WR, 0, 8'h00, "enable reset");
    rchk(ADDR_STAT, 0, 8'h00, "status reset");
    rchk(ADDR_VEND_HI, 0, 8'h00, "unmapped vendor");
    $display("test reset done");
    // write, set, clear; reserved and unimplemented bits stay zero
    accm_link_model_i.wr(ADDR_IEN_WR, 8'hFF, 0);
    for (int i = 0; i < 3; i++) rchk(6'(ADDR_IEN_WR + i), 0, 8'h23, "enable read");
    accm_link_model_i.wr(ADDR_IEN_CLR, 8'h03, 0);
    rchk(ADDR_IEN_SET, 0, 8'h20, "enable clear");
    accm_link_model_i.wr(ADDR_IEN_SET, 8'h01, 0);
    rchk(ADDR_IEN_CLR, 0, 8'h21, "enable set");
    accm_link_model_i.wr(ADDR_IEN_WR, 8'h02, 1);
    rchk(ADDR_IEN_WR, 1, 8'h02, "enable extended");
    accm_link_model_i.wr(ADDR_STAT, 8'hFF, 0);
    accm_link_model_i.wr(ADDR_LATCH, 8'hFF, 0);
    rchk(ADDR_STAT, 0, 8'h00, "status read only");
    rchk(ADDR_LATCH, 1, 8'h00, "latch read only");
    $display("test access done");
    // both id edges under each of the two enables
    for (int i = 0; i < 4; i++) begin
      accm_link_model_i.wr(ADDR_IEN_WR, i < 2 ? 8'h01 : 8'h02, 0);
      rx0 = accm_link_model_i.rx_cnt;
      ident_open_raw = ~ident_open_raw;
      ev = (i == 0 || i == 3);
      repeat (8) @(negedge clock);
      check("id alt count", 8'(accm_link_model_i.rx_cnt - rx0), {7'h00, ev});
      rchk(ADDR_STAT, 0, {7'h00, ident_open_raw}, "id status");
      rchk(ADDR_LATCH, 0, {7'h00, ev}, "id latch");
      rchk(ADDR_LATCH, 0, 8'h00, "latch cleared");
    end
    $display("test id events done");
    // codes 0-5 and 7; even passes enable here, odd passes the vendor enable
    for (int i = 0; i < 7; i++) begin
      resistor_code_raw = codes[i];
      accm_link_model_i.wr(ADDR_IEN_WR, i[0] ? 8'h00 : 8'h20, 0);
      rx0 = accm_link_model_i.rx_cnt;
      accm_link_model_i.wr(i[0] ? ADDR_RID_SET : ADDR_RID_WR, i[0] ? 8'h50 : 8'h10, 0);
      n = 0;
      while (resistor_measure_active !== 1'b1 && n < 10) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      while (resistor_measure_active === 1'b1 && n < 100) begin
        @(negedge clock);
        n++;
      end
      check("measure length", 8'(n), 8'(LEN));
      repeat (6) @(negedge clock);
      rchk(ADDR_STAT, 0, {2'b01, codes[i], 3'h0}, "done status");
      rchk(ADDR_LATCH, 0, 8'h08, "done latch");
      rchk(ADDR_STAT, 0, {2'b01, codes[i], 3'h0}, "done kept");
      rchk(ADDR_RID_SET, 0, {1'b0, i[0], 2'b00, 1'b1, codes[i]}, "vendor done");
      rchk(ADDR_STAT, 0, {2'b00, codes[i], 3'h0}, "done cleared");
      check("done alt count", 8'(accm_link_model_i.rx_cnt - rx0), 8'h01);
    end
    check("alt byte", accm_link_model_i.rx_last, {1'b1, rxcmd_low});
    $display("test measurement done");
    // clock enable low freezes the synchronisers, so the id edge waits for its return
    accm_link_model_i.wr(ADDR_IEN_WR, 8'h01, 0);
    rx0 = accm_link_model_i.rx_cnt;
    clk_en = 1'b0;
    ident_open_raw = 1'b1;
    repeat (8) @(negedge clock);
    check("frozen alt count", 8'(accm_link_model_i.rx_cnt - rx0), 8'h00);
    clk_en = 1'b1;
    repeat (8) @(negedge clock);
    check("thawed alt count", 8'(accm_link_model_i.rx_cnt - rx0), 8'h01);
    rchk(ADDR_LATCH, 0, 8'h01, "thawed latch");
    check("link handshakes lost", 8'(accm_link_model_i.lost), 8'h00);
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule
